/* src/aout_channel.v */
// One output channel: input latch, output latch and data conversion
`timescale 1ns/1ps
`include "aout_consts.vh"

module aout_channel (
  input wire i_clk,
  input wire i_rst,
  input wire i_wr,
  input wire [15:0] i_wdata,
  input wire i_load,
  output reg [`AOUT_DW-1:0] o_code
);

  reg [`AOUT_DW-1:0] in_latch_r;

  // Sign copies above bit 11 are dropped; inverting the sign bit gives offset binary
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      in_latch_r <= `AOUT_ZERO_CODE;
    end else if (i_wr) begin
      in_latch_r <= {~i_wdata[`AOUT_DW-1], i_wdata[`AOUT_DW-2:0]};
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_code <= `AOUT_ZERO_CODE;
    end else if (i_load) begin
      o_code <= in_latch_r;
    end
  end

endmodule

/* src/aout_consts.vh */
// Offsets, fields, reset values and codes of the analog output slave
`ifndef AOUT_CONSTS_VH
`define AOUT_CONSTS_VH

`define AOUT_NCH 8
`define AOUT_DW 12
`define AOUT_ZERO_CODE 12'h800
`define AOUT_BASE_W 9

`define AOUT_OFS_CTRL 7'h00
`define AOUT_OFS_TRIG 7'h04
`define AOUT_OFS_DAC0 7'h20

`define AOUT_CTRL_W 6
`define AOUT_CTRL_RST 6'h00
`define AOUT_CTRL_FIELD 0
`define AOUT_CTRL_LEDOFF 1
`define AOUT_CTRL_MODE_LO 2
`define AOUT_CTRL_MODE_HI 3
`define AOUT_CTRL_TDRV 4
`define AOUT_CTRL_TLVL 5

`define AOUT_MODE_AUTO 2'h0
`define AOUT_MODE_INT 2'h1
`define AOUT_MODE_EXTF 2'h2
`define AOUT_MODE_EXTR 2'h3

`define AOUT_TRIG_SW 0
`define AOUT_TRIG_LVL 0
`define AOUT_TRIG_DONE 1

`define AOUT_HSIZE_BYTE 3'h0
`define AOUT_HTRANS_NONSEQ 1

`endif

/* src/aout_slave.v */
// Eight-channel analog output control with AHB-Lite register slave
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "aout_consts.vh"

module aout_slave #(
  parameter NCH = `AOUT_NCH
) (
  input wire I_CLK,
  input wire I_SYS_RST,
  input wire I_HSEL,
  input wire [31:0] I_HADDR,
  input wire [1:0] I_HTRANS,
  input wire I_HWRITE,
  input wire [2:0] I_HSIZE,
  input wire [3:0] I_HPROT,
  input wire [31:0] I_HWDATA,
  input wire I_HREADY,
  output reg [31:0] O_HRDATA,
  output reg O_HREADYOUT,
  output reg O_HRESP,
  input wire [`AOUT_BASE_W-1:0] I_BASE_SEL,
  input wire I_AM2_SEL,
  input wire I_AM_BOTH,
  input wire I_EXT_TRIG_I,
  output reg O_EXT_TRIG_O,
  output reg O_EXT_TRIG_OE,
  output reg O_FIELD_CONNECT,
  output reg O_LED_ON,
  output reg [NCH*`AOUT_DW-1:0] O_DAC_CODE
);

  ////////////////////////////////////////////////////////////////////////////
  // Straps and trigger input synchroniser

  reg [`AOUT_BASE_W-1:0] base_r;
  reg am2_r;
  reg am_both_r;
  reg trig_s1_r;
  reg trig_s2_r;
  reg trig_s3_r;
  reg trig_lvl_r;
  reg trig_lvl_nxt;
  wire trig_rise;
  wire trig_fall;

  // Straps are static; one register stage keeps them off the decode path
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      base_r <= {`AOUT_BASE_W{1'b0}};
      am2_r <= 1'b0;
      am_both_r <= 1'b0;
    end else begin
      base_r <= I_BASE_SEL;
      am2_r <= I_AM2_SEL;
      am_both_r <= I_AM_BOTH;
    end
  end

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
      trig_lvl_r <= 1'b0;
    end else begin
      trig_s1_r <= I_EXT_TRIG_I;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      trig_lvl_r <= trig_lvl_nxt;
    end
  end

  // A change counts only once two stages agree
  always @* begin
    trig_lvl_nxt = trig_lvl_r;
    if (trig_s2_r == trig_s3_r) begin
      trig_lvl_nxt = trig_s3_r;
    end
  end

  assign trig_rise = trig_lvl_nxt & ~trig_lvl_r;
  assign trig_fall = ~trig_lvl_nxt & trig_lvl_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address phase decode

  wire addr_phase;
  wire am_ok;
  wire base_ok;
  wire dev_sel;
  wire is_ctrl;
  wire is_trig;
  wire is_dac;
  wire size_ok_gen;

  assign addr_phase = I_HSEL & I_HREADY & I_HTRANS[`AOUT_HTRANS_NONSEQ];
  // Privileged access stands for the supervisory modifier, user for nonprivileged
  assign am_ok = am_both_r | (I_HPROT[1] == am2_r);
  assign base_ok = (I_HADDR[15:7] == base_r) & (I_HPROT[1] == am2_r | am_both_r);
  assign dev_sel = addr_phase & am_ok & base_ok;
  assign is_ctrl = (I_HADDR[6:0] == `AOUT_OFS_CTRL);
  assign is_trig = (I_HADDR[6:0] == `AOUT_OFS_TRIG);
  assign is_dac = (I_HADDR[6:5] == 2'h1) & (I_HADDR[1:0] == 2'h0);
  // Byte writes reach the low byte lane only; DAC registers take no byte writes
  assign size_ok_gen = (I_HSIZE != `AOUT_HSIZE_BYTE) | (I_HADDR[1:0] == 2'h0);

  reg wr_ctrl_r;
  reg wr_trig_r;
  reg wr_dac_r;
  reg [2:0] wr_ch_r;

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wr_ctrl_r <= 1'b0;
      wr_trig_r <= 1'b0;
      wr_dac_r <= 1'b0;
      wr_ch_r <= 3'h0;
    end else begin
      wr_ctrl_r <= dev_sel & I_HWRITE & is_ctrl & size_ok_gen;
      wr_trig_r <= dev_sel & I_HWRITE & is_trig & size_ok_gen;
      wr_dac_r <= dev_sel & I_HWRITE & is_dac & (I_HSIZE != `AOUT_HSIZE_BYTE);
      wr_ch_r <= I_HADDR[4:2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control/status register and trigger register

  reg [`AOUT_CTRL_W-1:0] ctrl_r;
  reg done_r;
  reg done_nxt;
  reg load_all;
  wire [1:0] mode;
  wire any_load;
  reg auto_ld_r;
  reg [2:0] auto_ch_r;

  assign mode = ctrl_r[`AOUT_CTRL_MODE_HI:`AOUT_CTRL_MODE_LO];

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_r <= `AOUT_CTRL_RST;
    end else if (wr_ctrl_r) begin
      ctrl_r <= I_HWDATA[`AOUT_CTRL_W-1:0];
    end
  end

  always @* begin
    load_all = 1'b0;
    case (mode)
      `AOUT_MODE_INT: load_all = wr_trig_r & I_HWDATA[`AOUT_TRIG_SW];
      `AOUT_MODE_EXTF: load_all = trig_fall;
      `AOUT_MODE_EXTR: load_all = trig_rise;
      default: load_all = 1'b0;
    endcase
  end

  assign any_load = load_all | auto_ld_r;

  // Load-done flag; a load in the clearing cycle keeps it set
  always @* begin
    done_nxt = done_r;
    if (wr_trig_r & I_HWDATA[`AOUT_TRIG_DONE]) begin
      done_nxt = 1'b0;
    end
    if (any_load) begin
      done_nxt = 1'b1;
    end
  end

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      done_r <= 1'b0;
      auto_ld_r <= 1'b0;
      auto_ch_r <= 3'h0;
    end else begin
      done_r <= done_nxt;
      // Load one cycle after the input latch has taken the word
      auto_ld_r <= wr_dac_r & (mode == `AOUT_MODE_AUTO);
      auto_ch_r <= wr_ch_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  wire [NCH*`AOUT_DW-1:0] code;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      aout_channel u_ch (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_wr(wr_dac_r & ({29'h0, wr_ch_r} == g)),
        .i_wdata(I_HWDATA[15:0]),
        .i_load(load_all | (auto_ld_r & ({29'h0, auto_ch_r} == g))),
        .o_code(code[g*`AOUT_DW +: `AOUT_DW])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read path and bus answer

  reg [31:0] rdata_nxt;

  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (dev_sel & ~I_HWRITE) begin
      if (is_ctrl) begin
        rdata_nxt = {26'h0, ctrl_r};
      end else if (is_trig) begin
        rdata_nxt = {30'h0, done_r, trig_lvl_r};
      end else if (is_dac) begin
        rdata_nxt = {20'h0, code[I_HADDR[4:2]*`AOUT_DW +: `AOUT_DW]};
      end
    end
  end

  // Zero-wait answer: every selected cycle completes with OKAY in its data phase
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_HRDATA <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      O_HRDATA <= rdata_nxt;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_FIELD_CONNECT <= 1'b0;
      O_LED_ON <= 1'b1;
      O_EXT_TRIG_O <= 1'b0;
      O_EXT_TRIG_OE <= 1'b0;
      O_DAC_CODE <= {NCH{`AOUT_ZERO_CODE}};
    end else begin
      O_FIELD_CONNECT <= ctrl_r[`AOUT_CTRL_FIELD];
      O_LED_ON <= ~ctrl_r[`AOUT_CTRL_LEDOFF];
      O_EXT_TRIG_O <= ctrl_r[`AOUT_CTRL_TLVL];
      O_EXT_TRIG_OE <= ctrl_r[`AOUT_CTRL_TDRV];
      O_DAC_CODE <= code;
    end
  end

endmodule

/* testbench/ahb_host.sv */
// Register bus master model for single transfers
`timescale 1ns/1ps
module ahb_host (
  input wire i_clk,
  input wire i_hready,
  input wire [31:0] i_hrdata,
  output logic o_hsel = 1'b0,
  output logic [31:0] o_haddr = 32'h0,
  output logic [1:0] o_htrans = 2'h0,
  output logic o_hwrite = 1'b0,
  output logic [2:0] o_hsize = 3'h2,
  output logic [3:0] o_hprot = 4'h0,
  output logic [31:0] o_hwdata = 32'h0
);
  // Released address and write-data lines show inverted values so stale data never matches
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] s,
      input logic [3:0] p, output logic [31:0] r);
    o_hsel <= 1'b1;
    o_haddr <= a;
    o_htrans <= 2'h2;
    o_hwrite <= w;
    o_hsize <= s;
    o_hprot <= p;
    do @(posedge i_clk); while (!i_hready);
    o_hsel <= 1'b0;
    o_haddr <= ~a;
    o_htrans <= 2'h0;
    o_hwdata <= w ? d : ~d;
    do @(posedge i_clk); while (!i_hready);
    r = i_hrdata;
    o_hwdata <= ~d;
  endtask
endmodule

/* testbench/aout_slave_asserts.sv */
// Checker of bus answer, reset state and register side effects
`timescale 1ns/1ps
`include "aout_consts.vh"
module aout_slave_asserts #(parameter NCH = 8) (
  input wire I_CLK,
  input wire I_SYS_RST,
  input wire I_HSEL,
  input wire [31:0] I_HADDR,
  input wire [1:0] I_HTRANS,
  input wire I_HWRITE,
  input wire [`AOUT_BASE_W-1:0] I_BASE_SEL,
  input wire [31:0] O_HRDATA,
  input wire O_HREADYOUT,
  input wire O_HRESP,
  input wire O_EXT_TRIG_OE,
  input wire O_FIELD_CONNECT,
  input wire O_LED_ON,
  input wire [NCH*`AOUT_DW-1:0] O_DAC_CODE
);
  // Field, LED and trigger drive-enable outputs may only move two or three edges after a write
  wire wr = I_HSEL && I_HWRITE && I_HTRANS[1];
  default clocking dc @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_ready; O_HREADYOUT && !O_HRESP; endproperty
  a_ready: assert property (p_ready) else $error("bus answer late");
  property p_rst_dac; $fell(I_SYS_RST) |-> O_DAC_CODE == {NCH{`AOUT_ZERO_CODE}}; endproperty
  a_rst_dac: assert property (p_rst_dac) else $error("dac not zero");
  property p_rst_field; $fell(I_SYS_RST) |-> !O_FIELD_CONNECT; endproperty
  a_rst_field: assert property (p_rst_field) else $error("field on");
  property p_rst_ctrl; $fell(I_SYS_RST) |-> O_LED_ON && !O_EXT_TRIG_OE; endproperty
  a_rst_ctrl: assert property (p_rst_ctrl) else $error("ctrl not clear");
  property p_unsel; I_HSEL && I_HTRANS[1] && !I_HWRITE && I_HADDR[15:7] != I_BASE_SEL |=> O_HRDATA == 32'h0;
  endproperty
  a_unsel: assert property (p_unsel) else $error("foreign read answered");
  property p_field_src; $changed(O_FIELD_CONNECT) |-> $past(wr, 2) || $past(wr, 3); endproperty
  a_field_src: assert property (p_field_src) else $error("field moved alone");
  property p_led_src; $changed(O_LED_ON) |-> $past(wr, 2) || $past(wr, 3); endproperty
  a_led_src: assert property (p_led_src) else $error("led moved alone");
  property p_oe_src; $changed(O_EXT_TRIG_OE) |-> $past(wr, 2) || $past(wr, 3); endproperty
  a_oe_src: assert property (p_oe_src) else $error("drive moved alone");
endmodule

/* testbench/vme_analog_output_slave_control_tb.sv */
// Self-checking bench of the analog output slave
`timescale 1ns/1ps
`include "aout_consts.vh"
module vme_analog_output_slave_control_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic am_both = 1'b0;
  logic trig = 1'b0;
  logic [3:0] prot = 4'h2;
  logic [31:0] ba = 32'h5280;
  logic [31:0] r;
  // Written word, then expected offset-binary code
  logic [31:0] rows [8] = '{32'h0000_0800, 32'h07ff_0fff, 32'hf800_0000, 32'hffff_07ff, 32'h0001_0801,
    32'h5123_0923, 32'h8fff_07ff, 32'h0800_0000};
  int err_count = 0;
  int checks = 0;
  wire hsel, hwrite, rdy, resp, trig_o, trig_oe, field, led;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [3:0] hprot;
  wire [95:0] dac;
  always #2.5 clk = ~clk;
  ahb_host host (.i_clk(clk), .i_hready(rdy), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
    .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hprot(hprot), .o_hwdata(hwdata));
  aout_slave uut (.I_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HPROT(hprot), .I_HWDATA(hwdata), .I_HREADY(rdy), .O_HRDATA(hrdata),
    .O_HREADYOUT(rdy), .O_HRESP(resp), .I_BASE_SEL(9'h0a5), .I_AM2_SEL(1'b1), .I_AM_BOTH(am_both),
    .I_EXT_TRIG_I(trig), .O_EXT_TRIG_O(trig_o), .O_EXT_TRIG_OE(trig_oe), .O_FIELD_CONNECT(field),
    .O_LED_ON(led), .O_DAC_CODE(dac));
  task complete_run;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] s = 3'h2);
    host.xfer(1'b1, ba + a, d, s, prot, r);
  endtask
  task rd(input logic [31:0] a);
    host.xfer(1'b0, ba + a, 32'h0, 3'h2, prot, r);
  endtask
  task ck_dac(input int c, input logic [11:0] e);
    chk(32'(dac[c*12+:12]), 32'(e));
  endtask
  task ck_rst;
    for (int j = 0; j < 8; j++) ck_dac(j, `AOUT_ZERO_CODE);
    chk(32'({field, led, trig_oe}), 32'h2);
    rd(0);
    chk(r, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    wt(6);
    rst <= 1'b0;
    wt(2);
    ck_rst;
    $display("reset state done");
    for (int i = 0; i < 8; i++) begin
      wr(32'h20 + 4 * i, {16'h0, rows[i][31:16]});
      wt(3);
      ck_dac(i, rows[i][11:0]);
      rd(32'h20 + 4 * i);
      chk(r, {20'h0, rows[i][11:0]});
    end
    $display("table done");
    wr(0, 32'h3);
    wt(2);
    chk(32'({field, led}), 32'h2);
    wr(0, 32'h7);
    wr(32'h20, 32'h100);
    wr(32'h24, 32'h200);
    wt(3);
    ck_dac(0, 12'h800);
    wr(4, 32'h2);
    rd(4);
    chk(r, 32'h0);
    wr(4, 32'h1);
    wt(3);
    ck_dac(0, 12'h900);
    rd(4);
    chk(r, 32'h2);
    ck_dac(1, 12'ha00);
    $display("internal update done");
    wr(0, 32'hf);
    wr(32'h20, 32'h300);
    trig <= 1'b1;
    wt(8);
    ck_dac(0, 12'hb00);
    wr(0, 32'hb);
    wr(32'h20, 32'h400);
    wt(3);
    ck_dac(0, 12'hb00);
    trig <= 1'b0;
    wt(8);
    ck_dac(0, 12'hc00);
    $display("external update done");
    wr(0, 32'h30);
    wt(2);
    chk(32'({trig_oe, trig_o}), 32'h3);
    prot = 4'h0;
    wr(32'h2c, 32'h0);
    am_both <= 1'b1;
    wt(3);
    ck_dac(3, 12'h7ff);
    wr(32'h30, 32'h0);
    wt(3);
    ck_dac(4, 12'h800);
    am_both <= 1'b0;
    prot = 4'h2;
    ba = 32'h5300;
    wr(32'h34, 32'h0);
    rd(32'h34);
    chk(r, 32'h0);
    ba = 32'h5280;
    wr(32'h38, 32'h1, 3'h0);
    wt(3);
    ck_dac(5, 12'h923);
    ck_dac(6, 12'h7ff);
    $display("select and size done");
    rst <= 1'b1;
    // Two edges in reset so the output drop is masked from the checker
    wt(2);
    rst <= 1'b0;
    wt(2);
    ck_rst;
    $display("second reset done");
    complete_run;
  end
  initial begin
    wt(5000);
    err_count++;
    complete_run;
  end
endmodule
bind aout_slave aout_slave_asserts #(.NCH(NCH)) chk_i (.I_CLK, .I_SYS_RST, .I_HSEL, .I_HADDR, .I_HTRANS,
  .I_HWRITE, .I_BASE_SEL, .O_HRDATA, .O_HREADYOUT, .O_HRESP, .O_EXT_TRIG_OE, .O_FIELD_CONNECT, .O_LED_ON,
  .O_DAC_CODE);
